// *** cgg_counter_gate_generator.sv ***
// reference selection, prescaler and measurement gate with axi4-lite registers
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module cgg_counter_gate_generator (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic      [1:0]  bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic      [31:0] rdata,
	output logic      [1:0]  rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        refLineIn,
	output logic             refLineOut,
	output logic             refLineOe,
	output logic             convClk,
	output logic             intConvEn,
	output logic             extConvEn,
	output logic             gateOut,
	output logic             termOut
);
	logic        refSel_q;
	logic [2:0]  gateSel_q;
	logic [3:0]  intDiv_q;
	logic        intLvl_q;
	logic [2:0]  extSync_q;
	logic        extLvl_q;
	logic        arm_q;
	logic        armInit_q;
	logic        enable_q;
	logic        gatePend_q;
	logic        closePend_q;
	logic        gateOpen_q;
	logic [16:0] divCnt_q;
	logic        awHeld_q;
	logic        wHeld_q;
	logic [7:0]  awAddr_q;
	logic [31:0] wData_q;
	logic [3:0]  wStrb_q;
	logic [3:0]  stCnt [cgg_pkg::PRESC_STAGES];
	wire  [cgg_pkg::PRESC_STAGES:0] chain;

	// internal 10 MHz reference made from the system clock
	wire intWrap = (intDiv_q == cgg_pkg::INT_HALF_M1);
	wire intRise = intWrap & ~intLvl_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			intDiv_q <= 4'h0;
			intLvl_q <= 1'b0;
		end else if (intWrap) begin
			intDiv_q <= 4'h0;
			intLvl_q <= ~intLvl_q;
		end else begin
			intDiv_q <= intDiv_q + 4'h1;
		end
	end

	// external reference: a level change counts only once two stages agree
	wire extStable = (extSync_q[2] == extSync_q[1]);
	wire extRise   = extStable & extSync_q[2] & ~extLvl_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			extSync_q <= 3'h0;
			extLvl_q  <= 1'b0;
		end else begin
			extSync_q <= {extSync_q[1:0], refLineIn};
			if (extStable) begin
				extLvl_q <= extSync_q[2];
			end
		end
	end

	wire refTick = refSel_q ? intRise : extRise;
	wire selLvl  = refSel_q ? intLvl_q : extLvl_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			convClk    <= 1'b0;
			refLineOut <= 1'b0;
			refLineOe  <= 1'b0;
			intConvEn  <= 1'b0;
			extConvEn  <= 1'b0;
		end else begin
			convClk    <= selLvl;
			refLineOut <= intLvl_q;
			refLineOe  <= refSel_q;
			intConvEn  <= refSel_q;
			extConvEn  <= ~refSel_q;
		end
	end

	assign chain[0] = refTick;
	for (genvar g = 0; g < cgg_pkg::PRESC_STAGES; g++) begin : gPresc
		cgg_decade uStage (
			.clk     (clk),
			.reset_n (reset_n),
			.en      (chain[g]),
			.clr     (1'b0),
			.count   (stCnt[g]),
			.carry   (chain[g+1])
		);
	end
	wire tick = chain[cgg_pkg::PRESC_STAGES];

	wire [16:0] ratio   = cgg_pkg::gate_ratio(gateSel_q);
	wire [16:0] lastCnt = ratio - 17'h2;
	wire [16:0] wrapCnt = ratio - 17'h1;
	wire [16:0] halfCnt = ratio >> 1;

	// register decode
	wire wrFire   = awHeld_q & wHeld_q & ~bvalid;
	wire wrCtrl   = wrFire & (awAddr_q == cgg_pkg::ADDR_CTRL);
	wire wrArm    = wrFire & (awAddr_q == cgg_pkg::ADDR_ARM);
	wire wrMapped = (awAddr_q == cgg_pkg::ADDR_CTRL) | (awAddr_q == cgg_pkg::ADDR_ARM);
	wire swArmSet = wrArm & wStrb_q[0] & wData_q[cgg_pkg::ARM_BIT];
	wire swArmClr = wrArm & wStrb_q[0] & ~wData_q[cgg_pkg::ARM_BIT];

	// gate sequencing events, all qualified by the 100 kHz tick
	// completion of the selected count
	wire finish  = tick & gateOpen_q & enable_q & ~closePend_q & (divCnt_q == lastCnt);
	wire pendSet = tick & arm_q & armInit_q & ~gateOpen_q;
	wire enSet   = tick & ~arm_q & gatePend_q & ~enable_q;
	wire openEv  = tick & enable_q & gatePend_q & ~gateOpen_q & ~arm_q;
	wire closeEv = tick & closePend_q & gateOpen_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			arm_q     <= 1'b0;
			armInit_q <= 1'b0;
		end else begin
			// set wins over a simultaneous software clear
			if (swArmSet | finish) begin
				arm_q <= 1'b1;
			end else if (swArmClr) begin
				arm_q <= 1'b0;
			end
			if (swArmSet) begin
				armInit_q <= 1'b1;
			end else if (pendSet | swArmClr) begin
				armInit_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			enable_q <= 1'b0;
		end else if (arm_q | finish) begin
			enable_q <= 1'b0;
		end else if (enSet) begin
			enable_q <= 1'b1;
		end
	end

	// gate state moves only on tick
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gatePend_q  <= 1'b0;
			closePend_q <= 1'b0;
			gateOpen_q  <= 1'b0;
		end else begin
			if (pendSet) begin
				gatePend_q <= 1'b1;
			end else if (openEv) begin
				gatePend_q <= 1'b0;
			end
			if (finish) begin
				closePend_q <= 1'b1;
			end else if (closeEv) begin
				closePend_q <= 1'b0;
			end
			if (openEv) begin
				gateOpen_q <= 1'b1;
			end else if (closeEv) begin
				gateOpen_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			divCnt_q <= 17'h0;
		end else if (arm_q) begin
			divCnt_q <= 17'h0;
		end else if (tick) begin
			if (gateOpen_q & enable_q) begin
				divCnt_q <= divCnt_q + 17'h1;
			end else if (~enable_q) begin
				divCnt_q <= (divCnt_q >= wrapCnt) ? 17'h0 : divCnt_q + 17'h1;
			end else begin
				divCnt_q <= 17'h0;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			termOut <= 1'b0;
		end else begin
			termOut <= gateOpen_q & ~closePend_q & (divCnt_q >= halfCnt);
		end
	end

	assign gateOut = gateOpen_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			refSel_q  <= cgg_pkg::RST_REFSEL;
			gateSel_q <= cgg_pkg::RST_GATESEL;
		end else if (wrCtrl & wStrb_q[0]) begin
			refSel_q  <= wData_q[cgg_pkg::CTRL_REF_BIT];
			gateSel_q <= wData_q[cgg_pkg::CTRL_SEL_LSB +: 3];
		end
	end

	// axi4-lite write side: address and data may arrive in either order
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			awHeld_q <= 1'b0;
			wHeld_q  <= 1'b0;
			awready  <= 1'b0;
			wready   <= 1'b0;
			awAddr_q <= 8'h0;
			wData_q  <= 32'h0;
			wStrb_q  <= 4'h0;
			bvalid   <= 1'b0;
			bresp    <= cgg_pkg::RESP_OKAY;
		end else begin
			if (awready & awvalid) begin
				awHeld_q <= 1'b1;
				awAddr_q <= awaddr;
				awready  <= 1'b0;
			end else if (wrFire) begin
				awHeld_q <= 1'b0;
			end else if (~awHeld_q & ~bvalid) begin
				awready <= 1'b1;
			end
			if (wready & wvalid) begin
				wHeld_q <= 1'b1;
				wData_q <= wdata;
				wStrb_q <= wstrb;
				wready  <= 1'b0;
			end else if (wrFire) begin
				wHeld_q <= 1'b0;
			end else if (~wHeld_q & ~bvalid) begin
				wready <= 1'b1;
			end
			if (wrFire) begin
				bvalid <= 1'b1;
				bresp  <= wrMapped ? cgg_pkg::RESP_OKAY : cgg_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// read side; status is a live snapshot, reading has no side effect
	wire [31:0] ctrlWord = {28'h0, gateSel_q, refSel_q};
	wire [31:0] armWord  = {31'h0, arm_q};
	wire [31:0] statWord = {25'h0, refSel_q, termOut, closePend_q, gatePend_q,
	                        enable_q, arm_q, gateOpen_q};
	wire isCtrl = (araddr == cgg_pkg::ADDR_CTRL);
	wire isArm  = (araddr == cgg_pkg::ADDR_ARM);
	wire isStat = (araddr == cgg_pkg::ADDR_STAT);
	wire [31:0] rdMux = isCtrl ? ctrlWord : isArm ? armWord : isStat ? statWord : 32'h0;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= cgg_pkg::RESP_OKAY;
		end else if (arready & arvalid) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rdMux;
			rresp   <= (isCtrl | isArm | isStat) ? cgg_pkg::RESP_OKAY : cgg_pkg::RESP_SLVERR;
		end else if (rvalid & rready) begin
			rvalid <= 1'b0;
		end else if (~rvalid) begin
			arready <= 1'b1;
		end
	end

	// helper: ticks seen while the gate is open
	logic [16:0] widthCnt_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			widthCnt_q <= 17'h0;
		end else if (~gateOpen_q) begin
			widthCnt_q <= 17'h0;
		end else if (tick) begin
			widthCnt_q <= widthCnt_q + 17'h1;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	a_int_path: assert property (reset_n |=> intConvEn == $past(refSel_q))
		else $error("internal converter enable does not follow select");
	a_ext_path: assert property (!refSel_q |=> extConvEn && !refLineOe)
		else $error("external mode left driver on or converter off");
	a_ref_drive: assert property (refSel_q && reset_n |=> refLineOe && refLineOut == $past(intLvl_q))
		else $error("reference line not driven in internal mode");
	a_conv_clock: assert property (##1 convClk == $past(selLvl))
		else $error("converter clock is not the selected reference");
	a_presc_rate: assert property (tick |-> refTick && stCnt[0] == cgg_pkg::DEC_LAST
		&& stCnt[1] == cgg_pkg::DEC_LAST)
		else $error("prescaler tick not at count ninety-nine");
	a_free_run: assert property (tick && !arm_q && !enable_q && divCnt_q < wrapCnt
		|=> divCnt_q == $past(divCnt_q) + 17'h1)
		else $error("idle divider not free running");
	a_arm_clears: assert property (arm_q |=> !enable_q && divCnt_q == 17'h0)
		else $error("arm did not clear enable and divider");
	a_enable_set: assert property (enSet && !swArmSet |=> enable_q)
		else $error("enable not set after release");
	a_gate_open: assert property (openEv |=> gateOpen_q && divCnt_q == 17'h0)
		else $error("gate failed to open when enabled");
	a_term_high: assert property (gateOpen_q && !closePend_q && divCnt_q >= halfCnt
		|=> termOut)
		else $error("terminal output low in second half of gate");
	a_finish_arms: assert property (finish |=> arm_q && !enable_q && closePend_q ##1 !termOut)
		else $error("completion did not re-arm and pend close");
	a_gate_close: assert property (closeEv |=> !gateOpen_q)
		else $error("gate did not close on tick after terminal");
	a_gate_width: assert property ($fell(gateOpen_q) |-> widthCnt_q == $past(ratio))
		else $error("gate width differs from selected ratio");
endmodule

// *** cgg_decade.sv ***
// one decade counter stage with enable, clear and carry
`timescale 1ns/1ps
module cgg_decade (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       en,
	input  wire logic       clr,
	output logic      [3:0] count,
	output wire logic       carry
);
	wire atLast = (count == cgg_pkg::DEC_LAST);

	// carry is combinational so a cascade ripples in the same cycle
	assign carry = en & atLast;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= 4'h0;
		end else if (clr) begin
			count <= 4'h0;
		end else if (en) begin
			count <= atLast ? 4'h0 : count + 4'h1;
		end
	end
endmodule

// *** cgg_far_end.sv ***
// far-end model: external reference source and count chain gate timer
`timescale 1ns/1ps
module cgg_far_end (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        extRun,
	input  wire logic        refLineOut,
	input  wire logic        refLineOe,
	input  wire logic        gateOut,
	output logic             refLine,
	output logic      [31:0] gateLen
);
	logic [3:0]  phase_q;
	logic        idle_q;
	logic [31:0] run_q;

	// external 10 mhz source, 5 clk high then 5 low
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_q <= 4'h0;
			idle_q  <= 1'b0;
		end else begin
			phase_q <= (phase_q == 4'h9) ? 4'h0 : phase_q + 4'h1;
			idle_q  <= ~idle_q;
		end
	end

	// device owns the line only in internal mode
	// an undriven line toggles so a stale level cannot pass for a reference
	assign refLine = refLineOe ? refLineOut : (extRun ? (phase_q < 4'h5) : idle_q);

	// count chain times how long the gate stays open
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_q   <= 32'h0;
			gateLen <= 32'h0;
		end else if (gateOut) begin
			run_q <= run_q + 32'h1;
		end else if (run_q != 32'h0) begin
			gateLen <= run_q;
			run_q   <= 32'h0;
		end
	end
endmodule

// *** cgg_pkg.sv ***
// constants for the counter gate generator
package cgg_pkg;
	localparam int          CLK_HZ       = 100_000_000;
	localparam int          REF_HZ       = 10_000_000;
	localparam int          INT_HALF     = CLK_HZ / REF_HZ / 2;
	localparam logic [3:0]  INT_HALF_M1  = 4'(INT_HALF - 1);
	localparam int          PRESC_STAGES = 2;
	localparam logic [3:0]  DEC_LAST     = 4'h9;

	localparam logic [7:0]  ADDR_CTRL    = 8'h00;
	localparam logic [7:0]  ADDR_ARM     = 8'h04;
	localparam logic [7:0]  ADDR_STAT    = 8'h08;

	localparam int          CTRL_REF_BIT = 0;
	localparam int          CTRL_SEL_LSB = 1;
	localparam int          ARM_BIT      = 0;
	localparam int          ST_OPEN      = 0;
	localparam int          ST_ARM       = 1;
	localparam int          ST_ENABLE    = 2;
	localparam int          ST_PEND      = 3;
	localparam int          ST_CLOSE     = 4;
	localparam int          ST_TERM      = 5;
	localparam int          ST_REF       = 6;

	localparam logic        RST_REFSEL   = 1'h1;
	localparam logic [2:0]  RST_GATESEL  = 3'h1;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	localparam logic [16:0] RATIO_1      = 17'h0000a;
	localparam logic [16:0] RATIO_2      = 17'h00064;
	localparam logic [16:0] RATIO_3      = 17'h003e8;
	localparam logic [16:0] RATIO_4      = 17'h02710;
	localparam logic [16:0] RATIO_5      = 17'h186a0;

	// unused codes fall back to the shortest gate
	function automatic logic [16:0] gate_ratio(input logic [2:0] s);
		case (s)
			3'h1:    gate_ratio = RATIO_1;
			3'h2:    gate_ratio = RATIO_2;
			3'h3:    gate_ratio = RATIO_3;
			3'h4:    gate_ratio = RATIO_4;
			3'h5:    gate_ratio = RATIO_5;
			default: gate_ratio = RATIO_1;
		endcase
	endfunction
endpackage

// *** testbench.sv ***
// self-checking bench for the counter gate generator
`timescale 1ns/1ps
module testbench;
	logic        clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, refLine, refLineOut, refLineOe;
	logic        convClk, intConvEn, extConvEn, gateOut, termOut, extRun;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, gateLen, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	int          checked, badCount, len;

	cgg_counter_gate_generator uut (.clk(clk), .reset_n(reset_n), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .refLineIn(refLine), .refLineOut(refLineOut), .refLineOe(refLineOe),
		.convClk(convClk), .intConvEn(intConvEn), .extConvEn(extConvEn), .gateOut(gateOut),
		.termOut(termOut));
	cgg_far_end far (.clk(clk), .reset_n(reset_n), .extRun(extRun), .refLineOut(refLineOut),
		.refLineOe(refLineOe), .gateOut(gateOut), .refLine(refLine), .gateLen(gateLen));

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, badCount);
		if (badCount == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			badCount++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic hang(input string what);
		badCount++;
		$display("[ERR] %s expected done seen timeout", what);
		tally_and_finish();
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		int n;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (n == 50) hang("write");
		check("bresp", 32'(bresp), 32'(er));
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
		int n;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		v = rdata;
		rr = rresp;
		rready <= 1'b0;
		if (n == 50) hang("read");
	endtask

	// length of one high phase of convClk or refLineOut, in clk cycles
	task automatic hi_len(input logic pickConv, output int n);
		int i;
		logic lo;
		logic v;
		n = 0;
		lo = 1'b0;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			v = pickConv ? convClk : refLineOut;
			if (v !== 1'b1) begin
				if (n > 0) break;
				lo = 1'b1;
			end else if (lo) n++;
		end
	endtask

	task automatic wait_gate(input logic lvl);
		int n;
		for (n = 0; n < 20000; n++) begin
			@(posedge clk);
			if (gateOut === lvl) break;
		end
		if (n == 20000) hang("gate edge");
		#1;
	endtask

	task automatic t_reset();
		check("intConvEn", 32'(intConvEn), 32'h1);
		check("extConvEn", 32'(extConvEn), 32'h0);
		check("refLineOe", 32'(refLineOe), 32'h1);
		axi_rd(cgg_pkg::ADDR_CTRL, d, r);
		check("ctrl reset", d, {28'h0, cgg_pkg::RST_GATESEL, cgg_pkg::RST_REFSEL});
		hi_len(1'b0, len);
		check("ref out high", 32'(len), 32'h5);
		hi_len(1'b1, len);
		check("conv clk high", 32'(len), 32'h5);
		$display("test reset_and_internal done");
	endtask

	task automatic t_regs();
		for (int c = 0; c < 8; c++) begin
			axi_wr(cgg_pkg::ADDR_CTRL, 32'((c << 1) | 1), cgg_pkg::RESP_OKAY);
			axi_rd(cgg_pkg::ADDR_CTRL, d, r);
			check("gate code", d, 32'((c << 1) | 1));
		end
		axi_wr(8'h0c, 32'h1, cgg_pkg::RESP_SLVERR);
		axi_rd(8'h0c, d, r);
		check("unmapped rresp", 32'(r), 32'(cgg_pkg::RESP_SLVERR));
		check("unmapped rdata", d, 32'h0);
		$display("test registers done");
	endtask

	// one full measurement; code 7 must behave as the shortest ratio
	task automatic run_gate(input logic [31:0] ctrl, input string name);
		axi_wr(cgg_pkg::ADDR_CTRL, ctrl, cgg_pkg::RESP_OKAY);
		if (!ctrl[0]) begin
			repeat (5) @(posedge clk);
			check("ext intConvEn", 32'(intConvEn), 32'h0);
			check("ext extConvEn", 32'(extConvEn), 32'h1);
			check("ext refLineOe", 32'(refLineOe), 32'h0);
			hi_len(1'b1, len);
			check("ext conv high", 32'(len), 32'h5);
		end
		axi_wr(cgg_pkg::ADDR_ARM, 32'h1, cgg_pkg::RESP_OKAY);
		axi_rd(cgg_pkg::ADDR_STAT, d, r);
		check("armed state", 32'(d[2:0]), 32'h2);
		check("status refSel", 32'(d[6]), 32'(ctrl[0]));
		repeat (1100) @(posedge clk);
		axi_rd(cgg_pkg::ADDR_STAT, d, r);
		check("gate pending", 32'(d[3]), 32'h1);
		check("no early gate", 32'(gateOut), 32'h0);
		// clearing arm, which then stays low, releases the gate
		axi_wr(cgg_pkg::ADDR_ARM, 32'h0, cgg_pkg::RESP_OKAY);
		wait_gate(1'b1);
		axi_rd(cgg_pkg::ADDR_STAT, d, r);
		check("open state", 32'(d[2:0]), 32'h5);
		repeat (4000) @(posedge clk);
		check("term before mid", 32'(termOut), 32'h0);
		repeat (2000) @(posedge clk);
		check("term after mid", 32'(termOut), 32'h1);
		wait_gate(1'b0);
		check("gate length", gateLen, 32'(cgg_pkg::RATIO_1) * 32'h3e8);
		check("term at close", 32'(termOut), 32'h0);
		axi_rd(cgg_pkg::ADDR_STAT, d, r);
		check("closed state", 32'(d[2:0]), 32'h2);
		axi_wr(cgg_pkg::ADDR_ARM, 32'h0, cgg_pkg::RESP_OKAY);
		axi_rd(cgg_pkg::ADDR_STAT, d, r);
		check("idle arm", 32'(d[1]), 32'h0);
		repeat (3000) @(posedge clk);
		check("stays closed", 32'(gateOut), 32'h0);
		$display("test %s done", name);
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		reset_n = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, extRun} = '0;
		awaddr = 8'h0;
		araddr = 8'h0;
		wdata = 32'h0;
		wstrb = 4'hf;
		checked = 0;
		badCount = 0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_regs();
		run_gate(32'h3, "gate_internal");
		extRun <= 1'b1;
		run_gate(32'he, "gate_external_code7");
		tally_and_finish();
	end
endmodule
